/* File: mdu_pkg.sv */
// Constants, addresses and types of the nibble-bus multiply/divide unit
package mdu_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_SRC_LO   = 16'hff80;
  localparam logic [15:0] IDX_SRC_HI   = 16'hff81;
  localparam logic [15:0] IDX_DLO_LO   = 16'hff82;
  localparam logic [15:0] IDX_DLO_HI   = 16'hff83;
  localparam logic [15:0] IDX_DHI_LO   = 16'hff84;
  localparam logic [15:0] IDX_DHI_HI   = 16'hff85;
  localparam logic [15:0] IDX_FLAGS    = 16'hff86;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hff88;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hff89;

  // Byte addresses on the bus
  localparam logic [31:0] A_SRC_LO   = {14'h0000, IDX_SRC_LO, 2'h0};
  localparam logic [31:0] A_SRC_HI   = {14'h0000, IDX_SRC_HI, 2'h0};
  localparam logic [31:0] A_DLO_LO   = {14'h0000, IDX_DLO_LO, 2'h0};
  localparam logic [31:0] A_DLO_HI   = {14'h0000, IDX_DLO_HI, 2'h0};
  localparam logic [31:0] A_DHI_LO   = {14'h0000, IDX_DHI_LO, 2'h0};
  localparam logic [31:0] A_DHI_HI   = {14'h0000, IDX_DHI_HI, 2'h0};
  localparam logic [31:0] A_FLAGS    = {14'h0000, IDX_FLAGS, 2'h0};
  localparam logic [31:0] A_IRQ_STAT = {14'h0000, IDX_IRQ_STAT, 2'h0};
  localparam logic [31:0] A_IRQ_MASK = {14'h0000, IDX_IRQ_MASK, 2'h0};

  // Bit positions in the flag location
  localparam int FLAG_SIGN = 3;
  localparam int FLAG_OVF  = 2;
  localparam int FLAG_ZERO = 1;
  localparam int FLAG_RUN  = 0;

  // Bit positions in the interrupt status and mask
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF  = 1;

  // Reset values
  localparam logic       FLAG_RST = 1'h0;
  localparam logic [1:0] IRQ_RST  = 2'h0;

  // Calculation time and its length in clock cycles
  localparam int CLK_NS      = 10;
  localparam int CALC_NS     = 80;
  localparam int CALC_CYCLES = (CALC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] CALC_CNT = 4'(CALC_CYCLES);

  // Phases of a bus transfer
  typedef enum logic [1:0] {bs_idle, bs_write, bs_read} bus_state_t;

endpackage

/* File: mdu_unit.sv */
// Multiply/divide unit with 4-bit operand locations behind AHB-Lite
//
// Notes on behaviour
// RULE1 - Eight-bit source held as two nibbles
// RULE2 - Destination low byte held as nibbles
// RULE3 - Destination high byte held as nibbles
// RULE4 - Flag bit 3 shows negative result
// RULE5 - Flag bit 2 shows overflow
// RULE6 - Flag bit 1 shows zero result
// RULE7 - Flag bit 0 reads run status
// RULE8 - Software writes bit 0: divide or multiply
// RULE9 - Mode write starts operation, result, flags
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/10ps

module mdu_unit (
  // Clock, reset and enable
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Interrupt
  output logic             irq
);

  // Bus state
  mdu_pkg::bus_state_t bst;
  logic [31:0]         dp_addr;
  logic [3:0]          rd_val;
  logic                take;
  logic                wr_go;

  // Operands and flags
  logic [7:0]  source_operand;
  logic [15:0] dest;
  logic        sign_flag;
  logic        overflow_indicator;
  logic        zero_result_flag;
  logic        calc_mode;
  logic        busy;
  logic [3:0]  cnt;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;

  // Results
  logic [15:0] prod;
  logic [15:0] quot;
  logic [15:0] rem;
  logic        div_ovf;
  logic        start;
  logic        fin;

  // Transfer taken in the address phase; write lands in data phase
  assign take  = hsel && htrans[1] && hready;
  assign wr_go = ce && (bst == mdu_pkg::bs_write);
  assign start = wr_go && (dp_addr == mdu_pkg::A_FLAGS) && !busy;
  assign fin   = ce && busy && (cnt == 4'h1);

  // Bus phase tracking and read data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bst       <= mdu_pkg::bs_idle;
      dp_addr   <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else if (ce) begin
      case (bst)
        mdu_pkg::bs_read: begin
          hrdata    <= {28'h000_0000, rd_val};
          hreadyout <= 1'b1;
          bst       <= mdu_pkg::bs_idle;
        end
        default: begin
          if (take) begin
            dp_addr <= haddr;
            if (hwrite) begin
              bst <= mdu_pkg::bs_write;
            end else begin
              bst       <= mdu_pkg::bs_read;
              hreadyout <= 1'b0;
            end
          end else begin
            bst <= mdu_pkg::bs_idle;
          end
        end
      endcase
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    if (dp_addr == mdu_pkg::A_SRC_LO) begin
      rd_val = source_operand[3:0];
    end else if (dp_addr == mdu_pkg::A_SRC_HI) begin
      rd_val = source_operand[7:4];
    end else if (dp_addr == mdu_pkg::A_DLO_LO) begin
      rd_val = dest[3:0];
    end else if (dp_addr == mdu_pkg::A_DLO_HI) begin
      rd_val = dest[7:4];
    end else if (dp_addr == mdu_pkg::A_DHI_LO) begin
      rd_val = dest[11:8];
    end else if (dp_addr == mdu_pkg::A_DHI_HI) begin
      rd_val = dest[15:12];
    end else if (dp_addr == mdu_pkg::A_FLAGS) begin
      rd_val = {sign_flag, overflow_indicator,
                zero_result_flag, busy}; // see RULE7
    end else if (dp_addr == mdu_pkg::A_IRQ_STAT) begin
      rd_val = {2'h0, irq_status};
    end else if (dp_addr == mdu_pkg::A_IRQ_MASK) begin
      rd_val = {2'h0, irq_mask};
    end else begin
      rd_val = 4'h0;
    end
  end

  // Arithmetic on the loaded operands
  always_comb begin
    prod = {8'h00, source_operand} * {8'h00, dest[7:0]};
    quot = 16'h0000;
    rem  = 16'h0000;
    if (source_operand != 8'h00) begin
      quot = dest / {8'h00, source_operand};
      rem  = dest % {8'h00, source_operand};
    end
    div_ovf = (source_operand == 8'h00) || (quot[15:8] != 8'h00);
  end

  // Source operand nibbles, locked while running
  always_ff @(posedge clock) begin
    if (wr_go && !busy) begin
      if (dp_addr == mdu_pkg::A_SRC_LO) begin
        source_operand[3:0] <= hwdata[3:0]; // see RULE1
      end else if (dp_addr == mdu_pkg::A_SRC_HI) begin
        source_operand[7:4] <= hwdata[3:0]; // see RULE1
      end
    end
  end

  // Destination nibbles and the finished result
  always_ff @(posedge clock) begin
    if (fin) begin
      if (!calc_mode) begin
        dest <= prod; // see RULE9
      end else if (!div_ovf) begin
        dest <= {rem[7:0], quot[7:0]}; // see RULE9
      end
    end else if (wr_go && !busy) begin
      if (dp_addr == mdu_pkg::A_DLO_LO) begin
        dest[3:0] <= hwdata[3:0]; // see RULE2
      end else if (dp_addr == mdu_pkg::A_DLO_HI) begin
        dest[7:4] <= hwdata[3:0]; // see RULE2
      end else if (dp_addr == mdu_pkg::A_DHI_LO) begin
        dest[11:8] <= hwdata[3:0]; // see RULE3
      end else if (dp_addr == mdu_pkg::A_DHI_HI) begin
        dest[15:12] <= hwdata[3:0]; // see RULE3
      end
    end
  end

  // Mode select, run status and cycle count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      calc_mode <= mdu_pkg::FLAG_RST;
      busy      <= mdu_pkg::FLAG_RST;
      cnt       <= 4'h0;
    end else if (start) begin
      calc_mode <= hwdata[mdu_pkg::FLAG_RUN]; // see RULE8
      busy      <= 1'b1; // see RULE9
      cnt       <= mdu_pkg::CALC_CNT;
    end else if (ce && busy) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        busy <= 1'b0; // see RULE7
      end
    end
  end

  // Result flags, updated when a calculation ends
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sign_flag          <= mdu_pkg::FLAG_RST;
      overflow_indicator <= mdu_pkg::FLAG_RST;
      zero_result_flag   <= mdu_pkg::FLAG_RST;
    end else if (fin) begin
      if (!calc_mode) begin
        sign_flag          <= prod[15]; // see RULE4
        overflow_indicator <= 1'b0; // see RULE5
        zero_result_flag   <= (prod == 16'h0000); // see RULE6
      end else if (div_ovf) begin
        sign_flag          <= 1'b0;
        overflow_indicator <= 1'b1; // see RULE5
        zero_result_flag   <= 1'b0;
      end else begin
        sign_flag          <= quot[7]; // see RULE4
        overflow_indicator <= 1'b0;
        zero_result_flag   <= (quot[7:0] == 8'h00); // see RULE6
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= mdu_pkg::IRQ_RST;
    end else if (ce) begin
      if (wr_go && dp_addr == mdu_pkg::A_IRQ_STAT) begin
        irq_status <= irq_status & ~hwdata[1:0];
      end
      if (fin) begin
        irq_status[mdu_pkg::IRQ_DONE] <= 1'b1;
        if (calc_mode && div_ovf) begin
          irq_status[mdu_pkg::IRQ_OVF] <= 1'b1;
        end
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_mask <= mdu_pkg::IRQ_RST;
    end else if (wr_go && dp_addr == mdu_pkg::A_IRQ_MASK) begin
      irq_mask <= hwdata[1:0];
    end
  end

  // Interrupt level output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_status & irq_mask);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_src_write;
    wr_go && !busy && dp_addr == mdu_pkg::A_SRC_HI
      |=> source_operand[7:4] == $past(hwdata[3:0]);
  endproperty
  a_src_write: assert property (p_src_write) // see RULE1
    else $error("source high nibble not written");

  property p_dlo_write;
    wr_go && !busy && dp_addr == mdu_pkg::A_DLO_LO
      |=> dest[3:0] == $past(hwdata[3:0]);
  endproperty
  a_dlo_write: assert property (p_dlo_write) // see RULE2
    else $error("destination low byte not written");

  property p_dhi_write;
    wr_go && !busy && dp_addr == mdu_pkg::A_DHI_HI
      |=> dest[15:12] == $past(hwdata[3:0]);
  endproperty
  a_dhi_write: assert property (p_dhi_write) // see RULE3
    else $error("destination high byte not written");

  property p_sign;
    fin && !calc_mode |=> sign_flag == dest[15];
  endproperty
  a_sign: assert property (p_sign) // see RULE4
    else $error("sign flag does not follow product");

  property p_ovf;
    fin && calc_mode && source_operand == 8'h00
      |=> overflow_indicator && $stable(dest);
  endproperty
  a_ovf: assert property (p_ovf) // see RULE5
    else $error("divide by zero not flagged");

  property p_zero;
    fin && !calc_mode |=> zero_result_flag == (dest == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) // see RULE6
    else $error("zero flag wrong after multiply");

  property p_run;
    start |=> busy [*8];
  endproperty
  a_run: assert property (p_run) // see RULE7
    else $error("run status dropped too early");

  property p_done;
    fin |=> !busy && irq_status[mdu_pkg::IRQ_DONE];
  endproperty
  a_done: assert property (p_done) // see RULE9
    else $error("finish did not clear run or set event");

  // A stalled calculation keeps its place in the count
  property p_freeze;
    busy && !ce |=> busy && $stable(cnt);
  endproperty
  a_freeze: assert property (p_freeze) // see RULE7
    else $error("run status or count moved while frozen");

  // Operand writes are locked out while running
  property p_src_lock;
    wr_go && busy |=> $stable(source_operand);
  endproperty
  a_src_lock: assert property (p_src_lock) // see RULE1
    else $error("source operand changed while running");

endmodule

/* File: mdu_host.sv */
// AHB-Lite master model standing in for the CPU data bus
`timescale 1ns/10ps
module mdu_host (
  // Clock
  input  wire logic        clock,
  // Slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Master request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer, held until hready is sampled high
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    // Released lines show no stale value
    hwdata <= ~hwdata;
    haddr <= ~a;
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench of the multiply/divide unit
`timescale 1ns/10ps
module testbench;
  logic        clock, rst, ce, hreadyout, hresp, irq, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          failures, n_checks, cyc;

  mdu_unit dut_u (.clock(clock), .rst(rst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq));
  mdu_host host_u (.clock(clock), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  // Clock of 10 ns
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compare one value
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, string n);
    host_u.xfer(1'b0, a, 32'h0, q);
    chk(n, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic irqchk(input logic e);
    repeat (2) @(posedge clock);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // Reset values of flags and interrupt registers
  task automatic t_reset;
    rd(mdu_pkg::A_FLAGS, 32'h0, "flags");
    rd(mdu_pkg::A_IRQ_STAT, 32'h0, "stat");
    rd(mdu_pkg::A_IRQ_MASK, 32'h0, "mask");
    irqchk(1'b0);
    $display("test reset done");
  endtask

  // Operand nibbles write and read back; unmapped place reads zero
  task automatic t_regs;
    for (int i = 0; i < 6; i++) wr(mdu_pkg::A_SRC_LO + 32'(4 * i), 32'(i + 9));
    for (int i = 0; i < 6; i++)
      rd(mdu_pkg::A_SRC_LO + 32'(4 * i), 32'(i + 9),
         "nib");
    wr(mdu_pkg::A_FLAGS + 32'h4, 32'h5);
    rd(mdu_pkg::A_FLAGS + 32'h4, 32'h0, "unmapped");
    $display("test regs done");
  endtask

  // Load, start, stall, poll and judge one calculation
  task automatic calc(input logic [7:0] s, input logic [15:0] d,
    input logic m, input logic [15:0] e, input logic [3:0] f);
    logic [23:0] v;
    v = {d, s};
    for (int i = 0; i < 6; i++)
      wr(mdu_pkg::A_SRC_LO + 32'(4 * i), 32'(v[4 * i +: 4]));
    wr(mdu_pkg::A_FLAGS, {31'h0, m});
    host_u.xfer(1'b0, mdu_pkg::A_FLAGS, 32'h0, q);
    chk("run", 32'h1, {31'h0, q[0]});
    wr(mdu_pkg::A_SRC_LO, {28'h0, ~s[3:0]});
    ce <= 1'b0;
    repeat (4) @(posedge clock);
    ce <= 1'b1;
    for (int k = 0; k < 40 && q[0] !== 1'b0; k++)
      host_u.xfer(1'b0, mdu_pkg::A_FLAGS, 32'h0, q);
    chk("flags", {28'h0, f}, q);
    for (int i = 0; i < 4; i++)
      rd(mdu_pkg::A_DLO_LO + 32'(4 * i), 32'(e[4 * i +: 4]),
         "dest");
    rd(mdu_pkg::A_SRC_LO, {28'h0, s[3:0]}, "src");
    $display("test calc %h %h %b done", s, d, m);
  endtask

  // Sticky status, mask and clear by writing one
  task automatic t_irq;
    rd(mdu_pkg::A_IRQ_STAT, 32'h3, "stat");
    irqchk(1'b0);
    wr(mdu_pkg::A_IRQ_MASK, 32'h1);
    irqchk(1'b1);
    wr(mdu_pkg::A_IRQ_STAT, 32'h1);
    rd(mdu_pkg::A_IRQ_STAT, 32'h2, "stat");
    irqchk(1'b0);
    wr(mdu_pkg::A_IRQ_MASK, 32'h2);
    irqchk(1'b1);
    wr(mdu_pkg::A_IRQ_STAT, 32'h2);
    irqchk(1'b0);
    $display("test irq done");
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    failures = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_regs();
    calc(8'hff, 16'h00ff, 1'b0, 16'hfe01, 4'h8);
    calc(8'h12, 16'h3400, 1'b0, 16'h0000, 4'h2);
    calc(8'h40, 16'h1234, 1'b1, 16'h3448, 4'h0);
    calc(8'h02, 16'h0100, 1'b1, 16'h0080, 4'h8);
    calc(8'h01, 16'h1000, 1'b1, 16'h1000, 4'h4);
    calc(8'h00, 16'h5678, 1'b1, 16'h5678, 4'h4);
    t_irq();
    close_out();
  end
endmodule
